//--- rtl/uslr_defines.svh
`ifndef USLR_DEFINES_SVH
`define USLR_DEFINES_SVH
`define USLR_A_DATA 3'h0
`define USLR_A_IEN 3'h1
`define USLR_A_ISTAT 3'h2
`define USLR_A_LCTL 3'h3
`define USLR_A_MCTL 3'h4
`define USLR_A_LSTAT 3'h5
`define USLR_A_MSTAT 3'h6
`define USLR_A_SCR 3'h7
`define USLR_LCR_ENH 8'hBF
`define USLR_LCR_DIV_BIT 7
`define USLR_IER_SLEEP_BIT 4
`define USLR_IER_UPPER_MASK 8'hF0
`define USLR_EFR_UNLOCK_BIT 4
`define USLR_MCR_LOOP_BIT 4
`define USLR_MCR_UPPER_MASK 8'hE0
`define USLR_MCR_RTS_BIT 1
`define USLR_MCR_DTR_BIT 0
`define USLR_ISR_NOINT 8'h01
`define USLR_ISR_MODEM 8'h00
`define USLR_IER_MODEM_BIT 3
`define USLR_MSR_DELTA_MASK 8'h0F
`define USLR_ZERO8 8'h00
`define USLR_DELTA_NONE 4'h0
`define USLR_IER_RXDATA_BIT 0
`endif

//--- rtl/uslr_pkg.sv
`default_nettype none
package uslr_pkg;
  typedef enum logic {USLR_AWAKE, USLR_ASLEEP} uslr_pwr_e;
  typedef logic [7:0] uslr_byte_t;
endpackage : uslr_pkg
`default_nettype wire

//--- rtl/uslr_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "uslr_defines.svh"
module uslr_channel #(
  parameter logic [7:0] REV_CODE = 8'h01,
  parameter logic [7:0] ID_CODE = 8'h02
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sel,
  input wire logic wr,
  input wire logic rd,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rx_pin,
  input wire logic [3:0] modem_n,
  output logic [7:0] rdata,
  output logic tx_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic int_pending,
  output logic sleep_ready,
  output logic tx_load,
  output logic wake_event
);
  typedef struct packed {
    logic [7:0] transmit_holding, receive_holding, dll, divisor_high_byte, interrupt_enable, line_control, modem_control, enhanced_function, fifo_control, scratch_pad;
    logic [7:0] xon1, xon2, xoff1, xoff2;
    logic [3:0] delta;
    logic [3:0] modem_last;
    logic rx_last, rx_ready, thr_full;
  } uslr_ch_s;
  uslr_ch_s st_q, st_d;
  logic enh, divsel, idsel, loop, line_in;
  logic [3:0] modem_eff;
  // Loopback: transmit stream returns inside, pins quiet
  assign loop = st_q.modem_control[`USLR_MCR_LOOP_BIT];
  assign line_in = loop ? 1'b1 : rx_pin;
  assign modem_eff = loop ? {st_q.modem_control[`USLR_MCR_RTS_BIT], st_q.modem_control[`USLR_MCR_DTR_BIT], 2'h0} : ~modem_n;
  assign enh = (st_q.line_control == `USLR_LCR_ENH);
  assign divsel = st_q.line_control[`USLR_LCR_DIV_BIT] && !enh;
  assign idsel = divsel && st_q.dll == `USLR_ZERO8 && st_q.divisor_high_byte == `USLR_ZERO8;
  always_comb begin
    st_d = st_q;
    st_d.modem_last = modem_eff;
    st_d.delta = st_q.delta | (modem_eff ^ st_q.modem_last);
    st_d.rx_last = line_in;
    if (sel && rd) begin
      if (addr == `USLR_A_DATA && !st_q.line_control[`USLR_LCR_DIV_BIT]) st_d.rx_ready = 1'b0;
      if (addr == `USLR_A_MSTAT && !enh) st_d.delta = modem_eff ^ st_q.modem_last;
    end
    // Loopback frame transfer in one step; after the read clear so a new byte wins
    if (loop && st_q.thr_full) begin
      st_d.receive_holding = st_q.transmit_holding;
      st_d.rx_ready = 1'b1;
      st_d.thr_full = 1'b0;
    end else if (st_q.thr_full) begin
      st_d.thr_full = 1'b0;
    end
    if (sel && wr) begin
      unique case (addr)
        `USLR_A_DATA: begin
          if (divsel) st_d.dll = wdata;
          else if (!st_q.line_control[`USLR_LCR_DIV_BIT]) begin
            st_d.transmit_holding = wdata;
            st_d.thr_full = 1'b1;
          end
        end
        `USLR_A_IEN: begin
          if (divsel) st_d.divisor_high_byte = wdata;
          else if (!st_q.line_control[`USLR_LCR_DIV_BIT]) begin
            st_d.interrupt_enable = st_q.enhanced_function[`USLR_EFR_UNLOCK_BIT] ? wdata :
              ((st_q.interrupt_enable & `USLR_IER_UPPER_MASK) | (wdata & ~`USLR_IER_UPPER_MASK));
          end
        end
        `USLR_A_ISTAT: if (enh) st_d.enhanced_function = wdata; else st_d.fifo_control = wdata;
        `USLR_A_LCTL: st_d.line_control = wdata;
        `USLR_A_MCTL: begin
          if (enh) st_d.xon1 = wdata;
          else st_d.modem_control = st_q.enhanced_function[`USLR_EFR_UNLOCK_BIT] ? wdata :
            ((st_q.modem_control & `USLR_MCR_UPPER_MASK) | (wdata & ~`USLR_MCR_UPPER_MASK));
        end
        `USLR_A_LSTAT: if (enh) st_d.xon2 = wdata;
        `USLR_A_MSTAT: if (enh) st_d.xoff1 = wdata;
        `USLR_A_SCR: if (enh) st_d.xoff2 = wdata; else st_d.scratch_pad = wdata;
      endcase
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.rx_last <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
  logic [7:0] isr_v;
  assign int_pending = (st_q.rx_ready && st_q.interrupt_enable[`USLR_IER_RXDATA_BIT]) ||
    ((|st_q.delta) && st_q.interrupt_enable[`USLR_IER_MODEM_BIT]);
  assign isr_v = int_pending ? `USLR_ISR_MODEM : `USLR_ISR_NOINT;
  always_comb begin
    rdata = `USLR_ZERO8;
    unique case (addr)
      `USLR_A_DATA: rdata = idsel ? REV_CODE : divsel ? st_q.dll : st_q.receive_holding;
      `USLR_A_IEN: rdata = idsel ? ID_CODE : divsel ? st_q.divisor_high_byte : st_q.interrupt_enable;
      `USLR_A_ISTAT: rdata = enh ? st_q.enhanced_function : isr_v;
      `USLR_A_LCTL: rdata = st_q.line_control;
      `USLR_A_MCTL: rdata = enh ? st_q.xon1 : st_q.modem_control;
      `USLR_A_LSTAT: rdata = enh ? st_q.xon2 : {2'h3, 5'h0, st_q.rx_ready};
      `USLR_A_MSTAT: rdata = enh ? st_q.xoff1 : {modem_eff, st_q.delta};
      `USLR_A_SCR: rdata = enh ? st_q.xoff2 : st_q.scratch_pad;
    endcase
  end
  assign tx_pin = 1'b1;
  assign rts_n = loop ? 1'b1 : ~st_q.modem_control[`USLR_MCR_RTS_BIT];
  assign dtr_n = loop ? 1'b1 : ~st_q.modem_control[`USLR_MCR_DTR_BIT];
  assign tx_load = sel && wr && addr == `USLR_A_DATA && !st_q.line_control[`USLR_LCR_DIV_BIT];
  assign wake_event = (st_q.rx_last && !line_in) || (|(modem_eff ^ st_q.modem_last));
  assign sleep_ready = !int_pending && st_q.interrupt_enable[`USLR_IER_SLEEP_BIT] &&
    ({st_q.divisor_high_byte, st_q.dll} != 16'h0000) &&
    (st_q.delta == `USLR_DELTA_NONE) && line_in;
endmodule : uslr_channel
`default_nettype wire

//--- rtl/uslr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "uslr_defines.svh"
module uslr_top #(
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] ID_CODE = 8'h02 // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CHANNEL_A_SELECT_N,
  input wire logic CHANNEL_B_SELECT_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] DATA_IN,
  input wire logic [1:0] RX,
  input wire logic [7:0] MODEM_N,
  output logic [7:0] DATA_OUT,
  output logic [1:0] TX,
  output logic [1:0] RTS_N,
  output logic [1:0] DTR_N,
  output logic [1:0] IRQ,
  output logic OSC_RUN,
  output logic OSCILLATOR_OUTPUT_PIN
);
  typedef struct packed {
    uslr_pkg::uslr_pwr_e pwr;
    logic [7:0] dout;
    logic [1:0] tx, rts_n, dtr_n, irq;
    logic osc;
    logic run;
  } uslr_top_s;
  uslr_top_s st_q, st_d;
  logic [1:0] sel, ready, pend, load, wake, tx_c, rts_c, dtr_c;
  logic [7:0] rd_c [2];
  assign sel = {~CHANNEL_B_SELECT_N, ~CHANNEL_A_SELECT_N};
  for (genvar i = 0; i < 2; i++) begin : g_ch
    uslr_channel #(.REV_CODE(REV_CODE), .ID_CODE(ID_CODE)) u_ch (
      .clk(CLK),
      .resetn(RESETN),
      .sel(sel[i]),
      .wr(~WR_N),
      .rd(~RD_N),
      .addr(ADDR),
      .wdata(DATA_IN),
      .rx_pin(RX[i]),
      .modem_n(MODEM_N[4*i+:4]),
      .rdata(rd_c[i]),
      .tx_pin(tx_c[i]),
      .rts_n(rts_c[i]),
      .dtr_n(dtr_c[i]),
      .int_pending(pend[i]),
      .sleep_ready(ready[i]),
      .tx_load(load[i]),
      .wake_event(wake[i])
    );
  end
  always_comb begin
    st_d = st_q;
    st_d.dout = sel[1] ? rd_c[1] : rd_c[0];
    st_d.tx = tx_c;
    st_d.rts_n = rts_c;
    st_d.dtr_n = dtr_c;
    st_d.irq = pend;
    unique case (st_q.pwr)
      uslr_pkg::USLR_AWAKE: if (&ready && !(|wake) && !(|load)) st_d.pwr = uslr_pkg::USLR_ASLEEP;
      uslr_pkg::USLR_ASLEEP: if ((|wake) || (|load) || !(&ready)) st_d.pwr = uslr_pkg::USLR_AWAKE;
    endcase
    st_d.osc = (st_d.pwr == uslr_pkg::USLR_AWAKE) ? ~st_q.osc : 1'b0;
    st_d.run = (st_d.pwr == uslr_pkg::USLR_AWAKE);
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= '0;
      st_q.tx <= 2'h3;
      st_q.rts_n <= 2'h3;
      st_q.dtr_n <= 2'h3;
      st_q.run <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
  assign DATA_OUT = st_q.dout;
  assign TX = st_q.tx;
  assign RTS_N = st_q.rts_n;
  assign DTR_N = st_q.dtr_n;
  assign IRQ = st_q.irq;
  assign OSC_RUN = st_q.run;
  assign OSCILLATOR_OUTPUT_PIN = st_q.osc;
endmodule : uslr_top
`default_nettype wire

//--- bench/uslr_chk.sv
`timescale 1ns/10ps
`default_nettype none
module uslr_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [1:0] RX,
  input wire logic [7:0] MODEM_N,
  input wire logic [1:0] TX,
  input wire logic [1:0] IRQ,
  input wire logic OSC_RUN,
  input wire logic OSCILLATOR_OUTPUT_PIN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_asleep;
    !OSC_RUN [*2];
  endsequence
  sequence s_awake;
    OSC_RUN [*3];
  endsequence
  osc_halt_a: assert property (s_asleep |-> !OSCILLATOR_OUTPUT_PIN)
    else $error("clock seen asleep");
  osc_toggle_a: assert property (s_awake |-> OSCILLATOR_OUTPUT_PIN != $past(OSCILLATOR_OUTPUT_PIN))
    else $error("clock stuck awake");
  irq_awake_a: assert property ((IRQ != 2'h0) [*2] |-> OSC_RUN)
    else $error("asleep with irq");
  rx_wake_a: assert property (!OSC_RUN && RX != 2'h3 |-> ##[0:2] OSC_RUN)
    else $error("no rx wake");
  modem_wake_a: assert property (!OSC_RUN && $changed(MODEM_N) |-> ##[0:2] OSC_RUN)
    else $error("no modem wake");
  tx_mark_a: assert property (TX == 2'h3)
    else $error("tx not marking");
  sleep_rx_a: assert property ($fell(OSC_RUN) |-> $past(RX) == 2'h3)
    else $error("slept with rx low");
  sleep_irq_a: assert property ($fell(OSC_RUN) |-> IRQ == 2'h0)
    else $error("slept with irq");
endmodule : uslr_chk
bind uslr_top uslr_chk chk_u (.CLK(CLK), .RESETN(RESETN), .RX(RX), .MODEM_N(MODEM_N), .TX(TX), .IRQ(IRQ),
  .OSC_RUN(OSC_RUN), .OSCILLATOR_OUTPUT_PIN(OSCILLATOR_OUTPUT_PIN));
`default_nettype wire

//--- bench/uslr_host.sv
`timescale 1ns/10ps
`default_nettype none
module uslr_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic cs_a_n,
  output logic cs_b_n,
  output logic wr_n,
  output logic rd_n,
  output logic [2:0] addr,
  output logic [7:0] wdata
);
  initial begin
    {cs_a_n, cs_b_n, wr_n, rd_n} = 4'hF;
    addr = 3'h0;
    wdata = 8'h00;
  end
  // One access held over one edge, released bus shows inverse
  task automatic acc(input logic ch, input logic w, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    #1;
    cs_a_n = ch;
    cs_b_n = !ch;
    wr_n = !w;
    rd_n = w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    q = rdata;
    {cs_a_n, cs_b_n, wr_n, rd_n} = 4'hF;
    addr = ~a;
    wdata = ~d;
  endtask : acc
endmodule : uslr_host
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_a_n, cs_b_n, wr_n, rd_n, osc_run, osc_pin;
  logic [2:0] addr;
  logic [7:0] din, dout, q;
  logic [7:0] modem_n = 8'hFF;
  logic [1:0] rx = 2'h3;
  logic [1:0] tx, rts_n, dtr_n, irq;
  int n_errors = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  uslr_host host_u (.clk(clk), .rdata(dout), .cs_a_n(cs_a_n), .cs_b_n(cs_b_n), .wr_n(wr_n), .rd_n(rd_n),
    .addr(addr), .wdata(din));
  uslr_top dut_u (.CLK(clk), .RESETN(resetn), .CHANNEL_A_SELECT_N(cs_a_n), .CHANNEL_B_SELECT_N(cs_b_n),
    .WR_N(wr_n), .RD_N(rd_n), .ADDR(addr), .DATA_IN(din), .RX(rx), .MODEM_N(modem_n), .DATA_OUT(dout),
    .TX(tx), .RTS_N(rts_n), .DTR_N(dtr_n), .IRQ(irq), .OSC_RUN(osc_run), .OSCILLATOR_OUTPUT_PIN(osc_pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    host_u.acc(ch, 1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic ch, input logic [2:0] a, input logic [7:0] exp);
    host_u.acc(ch, 1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic osc_is(input logic v);
    for (int k = 0; k < 8 && osc_run !== v; k++) idle(1);
    chk(8'(osc_run), 8'(v));
  endtask : osc_is
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    idle(16);
    resetn = 1'b1;
    wr(0, 3'h7, 8'h5A);
    wr(1, 3'h7, 8'hA5);
    rd(0, 3'h7, 8'h5A);
    rd(1, 3'h7, 8'hA5);
    rd(0, 3'h2, 8'h01);
    wr(1, 3'h1, 8'h10);
    rd(1, 3'h1, 8'h00);
    wr(0, 3'h3, 8'h80);
    rd(0, 3'h0, 8'h01);
    rd(0, 3'h1, 8'h02);
    wr(0, 3'h0, 8'h01);
    rd(0, 3'h0, 8'h01);
    rd(0, 3'h1, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(i[0], 3'h3, 8'hBF);
      wr(i[0], 3'h2, 8'h10);
      for (int a = 4; a < 8; a++) wr(i[0], 3'(a), 8'(8'h30 + a));
      wr(i[0], 3'h3, 8'h03);
      wr(i[0], 3'h5, 8'h99);
      wr(i[0], 3'h6, 8'h99);
      wr(i[0], 3'h1, 8'h10);
      rd(i[0], 3'h1, 8'h10);
      rd(i[0], 3'h3, 8'h03);
      wr(i[0], 3'h3, 8'hBF);
      rd(i[0], 3'h2, 8'h10);
      for (int a = 4; a < 8; a++) rd(i[0], 3'(a), 8'(8'h30 + a));
      wr(i[0], 3'h3, 8'h03);
    end
    idle(6);
    osc_is(1);
    wr(1, 3'h3, 8'h80);
    wr(1, 3'h0, 8'h01);
    wr(1, 3'h3, 8'h03);
    osc_is(0);
    chk(8'(osc_pin), 8'h00);
    rx[1] = 1'b0;
    osc_is(1);
    rx[1] = 1'b1;
    osc_is(0);
    modem_n[2] = 1'b0;
    osc_is(1);
    idle(6);
    osc_is(1);
    rd(0, 3'h6, 8'h44);
    osc_is(0);
    wr(1, 3'h0, 8'h55);
    osc_is(1);
    osc_is(0);
    wr(0, 3'h1, 8'h00);
    idle(6);
    osc_is(1);
    wr(0, 3'h4, 8'h13);
    rd(0, 3'h4, 8'h13);
    chk({5'h00, rts_n[0], dtr_n[0], tx[0]}, 8'h07);
    wr(1, 3'h4, 8'h03);
    idle(1);
    chk({6'h00, rts_n[1], dtr_n[1]}, 8'h00);
    wr(0, 3'h1, 8'h01);
    wr(0, 3'h0, 8'h3C);
    idle(2);
    chk(8'(irq[0]), 8'h01);
    rd(0, 3'h0, 8'h3C);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
